// ---- hdl/event_status_summary.v ----
// status byte, standard event and instrument event registers with command access
// assumes a decoder that issues one command code per cycle with its data byte
`timescale 1ns/1ps
`include "event_status_defines.vh"
module event_status_summary #(
   parameter RESP_WIDTH = 14
) (
   // clock and reset
   input  wire                  clk_sys_i,
   input  wire                  rstn_i,
   // decoded commands
   input  wire                  cmd_valid_i,
   input  wire [3:0]            cmd_code_i,
   input  wire [7:0]            cmd_data_i,
   input  wire                  cmd_has_param_i,
   input  wire                  cmd_takes_param_i,
   input  wire                  cmd_from_parallel_i,
   input  wire [RESP_WIDTH-1:0] resp_len_i,
   // interface messages
   input  wire                  msg_dev_clear_i,
   input  wire                  msg_go_local_i,
   input  wire                  msg_lockout_i,
   input  wire                  msg_remote_i,
   input  wire                  msg_trigger_i,
   input  wire                  serial_poll_i,
   // instrument state
   input  wire                  trig_external_i,
   input  wire                  comp_busy_i,
   input  wire                  output_pending_i,
   input  wire [3:0]            selftest_result_i,
   input  wire [7:0]            meas_event_i,
   input  wire [5:0]            compare_i,
   input  wire                  compare_valid_i,
   input  wire                  power_on_event_i,
   // responses
   output reg                   resp_valid_o,
   output reg  [7:0]            resp_data_o,
   output reg                   status_byte_o,
   // control outputs
   output reg                   srq_o,
   output reg                   remote_o,
   output reg                   panel_locked_o,
   output reg                   flush_buffers_o,
   output reg                   sample_once_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   reg  [7:0] srq_mask_reg;
   reg  [7:0] std_event_enable_mask;
   reg  [7:0] measurement_event_mask;
   reg  [7:0] comparator_event_mask;
   reg  [7:0] std_event_reg;
   reg  [7:0] std_event_next;
   reg  [7:0] status_byte_reg;
   reg        master_prev_reg;
   wire [7:0] measurement_event_flags;
   wire [7:0] comparator_event_flags;

   // decoding used by both the clear path and the main command path
   function is_cmd;
      input       valid;
      input [3:0] code;
      input [3:0] want;
      begin
         is_cmd = valid && (code == want);
      end
   endfunction

   wire cls_hit   = is_cmd(cmd_valid_i, cmd_code_i, `CMD_CLS);
   wire rd_meas   = is_cmd(cmd_valid_i, cmd_code_i, `CMD_READ_MEAS);
   wire rd_comp   = is_cmd(cmd_valid_i, cmd_code_i, `CMD_READ_COMP);
   wire rd_std    = is_cmd(cmd_valid_i, cmd_code_i, `CMD_READ_ESR);
   wire trg_hit   = is_cmd(cmd_valid_i, cmd_code_i, `CMD_TRIGGER);
   wire is_query  = cmd_valid_i && (cmd_code_i == `CMD_READ_STB || cmd_code_i == `CMD_READ_SRE
                    || cmd_code_i == `CMD_READ_ESR || cmd_code_i == `CMD_READ_ESE
                    || cmd_code_i == `CMD_READ_MEAS || cmd_code_i == `CMD_READ_MMASK
                    || cmd_code_i == `CMD_READ_COMP || cmd_code_i == `CMD_READ_CMASK
                    || cmd_code_i == `CMD_SELFTEST);

   ////////////////////////////////////////////////////////////////////////////////
   // event inputs
   wire [7:0] meas_set = meas_event_i & `MEAS_USED_MASK;
   wire [7:0] cmp_set;
   assign cmp_set[5:0] = compare_valid_i ? compare_i : 6'h00;
   // both pass bit is derived from the pass inputs of the same sample
   assign cmp_set[`CMP_BOTH_PASS] = compare_valid_i & compare_i[`CMP_FIRST_PASS]
                                    & compare_i[`CMP_THIRD_PASS];
   assign cmp_set[7] = 1'b0;

   event_flag_reg #(
      .WIDTH(8)
   ) u_meas_flags (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .set_i     (meas_set),
      .clear_i   (cls_hit | rd_meas),
      .flags_o   (measurement_event_flags)
   );

   event_flag_reg #(
      .WIDTH(8)
   ) u_comp_flags (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .set_i     (cmp_set),
      .clear_i   (cls_hit | rd_comp),
      .flags_o   (comparator_event_flags)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // error classes feed the standard event register
   wire exec_err = (trg_hit && !trig_external_i)
                   || (cmd_valid_i && comp_busy_i && cmd_code_i != `CMD_NONE)
                   || (is_cmd(cmd_valid_i, cmd_code_i, `CMD_WRITE_ESE)
                       && !cmd_from_parallel_i);
   wire query_err = is_query && (resp_len_i > `RESP_LIMIT);
   wire cmd_err   = cmd_valid_i && cmd_has_param_i && !cmd_takes_param_i;

   always @* begin
      std_event_next = 8'h00;
      std_event_next[`SEV_EXEC_ERR]  = exec_err;
      std_event_next[`SEV_QUERY_ERR] = query_err;
      std_event_next[`SEV_CMD_ERR]   = cmd_err;
      std_event_next[7]              = power_on_event_i;
   end

   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         std_event_reg <= `RESET_BYTE;
      end else if (cls_hit || rd_std) begin
         std_event_reg <= std_event_next;
      end else begin
         std_event_reg <= std_event_reg | std_event_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // summaries are combinational so they track flags and masks at once
   wire meas_sum = |(measurement_event_flags & measurement_event_mask);
   wire comp_sum = |(comparator_event_flags & comparator_event_mask);
   wire std_sum  = |(std_event_reg & std_event_enable_mask);

   reg [7:0] stb_live;
   always @* begin
      stb_live = 8'h00;
      stb_live[`STB_MEAS_SUM]  = meas_sum;
      stb_live[`STB_COMP_SUM]  = comp_sum;
      stb_live[`STB_MSG_AVAIL] = output_pending_i;
      stb_live[`STB_STD_SUM]   = std_sum;
      stb_live[`STB_MASTER]    = |(stb_live & srq_mask_reg & 8'hBF);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mask writes
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         srq_mask_reg           <= `RESET_BYTE;
         std_event_enable_mask  <= `RESET_BYTE;
         measurement_event_mask <= `RESET_BYTE;
         comparator_event_mask  <= `RESET_BYTE;
      end else if (cmd_valid_i && !comp_busy_i) begin
         case (cmd_code_i)
            `CMD_WRITE_SRE: begin
               srq_mask_reg <= cmd_data_i;
            end
            `CMD_WRITE_ESE: begin
               if (cmd_from_parallel_i) begin
                  std_event_enable_mask <= cmd_data_i;
               end
            end
            `CMD_WRITE_MMASK: begin
               measurement_event_mask <= cmd_data_i;
            end
            `CMD_WRITE_CMASK: begin
               comparator_event_mask <= cmd_data_i;
            end
            default: begin
               srq_mask_reg <= srq_mask_reg;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // query answers; an oversize response is dropped
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         resp_valid_o  <= 1'b0;
         resp_data_o   <= `RESET_BYTE;
         status_byte_o <= 1'b0;
      end else begin
         resp_valid_o  <= is_query && !query_err && !msg_dev_clear_i;
         status_byte_o <= serial_poll_i;
         if (serial_poll_i) begin
            resp_data_o <= {status_byte_reg[7], srq_o, status_byte_reg[5:0]};
         end else if (is_query) begin
            case (cmd_code_i)
               `CMD_READ_STB:   resp_data_o <= stb_live;
               `CMD_READ_SRE:   resp_data_o <= srq_mask_reg;
               `CMD_READ_ESR:   resp_data_o <= std_event_reg;
               `CMD_READ_ESE:   resp_data_o <= std_event_enable_mask;
               `CMD_READ_MEAS:  resp_data_o <= measurement_event_flags;
               `CMD_READ_MMASK: resp_data_o <= measurement_event_mask;
               `CMD_READ_COMP:  resp_data_o <= comparator_event_flags;
               `CMD_READ_CMASK: resp_data_o <= comparator_event_mask;
               `CMD_SELFTEST:   resp_data_o <= {4'h0, selftest_result_i} & `SELFTEST_MAX;
               default:         resp_data_o <= resp_data_o;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // service request: raised on a rising master summary, cleared by serial poll
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_byte_reg <= `RESET_BYTE;
         master_prev_reg <= 1'b0;
         srq_o           <= 1'b0;
      end else begin
         status_byte_reg <= stb_live;
         master_prev_reg <= stb_live[`STB_MASTER];
         if (stb_live[`STB_MASTER] && !master_prev_reg) begin
            srq_o <= 1'b1;
         end else if (serial_poll_i) begin
            srq_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interface messages
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         remote_o        <= 1'b0;
         panel_locked_o  <= 1'b0;
         flush_buffers_o <= 1'b0;
         sample_once_o   <= 1'b0;
      end else begin
         flush_buffers_o <= msg_dev_clear_i;
         // one pulse per trigger message or command, only in external mode and while not busy
         sample_once_o   <= (msg_trigger_i || trg_hit) && trig_external_i
                            && !comp_busy_i;
         if (msg_go_local_i) begin
            remote_o       <= 1'b0;
            panel_locked_o <= 1'b0;
         end else begin
            if (msg_remote_i) begin
               remote_o <= 1'b1;
            end
            if (msg_lockout_i) begin
               panel_locked_o <= 1'b1;
            end
         end
      end
   end

endmodule

// ---- hdl/event_status_defines.vh ----
// constants for the instrument status reporting block
// assumes a command decoder upstream that presents one decoded command per cycle
//
// What this block does
// - standard enable mask gates standard event bits
// - two eight-bit instrument event registers, readable
// - masked register zero sets status bit 0
// - masked register one sets status bit 1
// - clear on clear-status, own query, power-on
// - register zero holds overflow and done flags
// - register one bits 2..0 first-parameter result
// - register one bits 5..3 third-parameter result
// - register one bit 6 is pass AND
// - register zero query-only, mask read/write
// - register one query-only, mask read/write
// - service request mask stored, read back
// - standard mask written only over parallel bus
// - standard event query returns register byte
// - device clear empties input and output
// - go-to-local leaves remote state
// - local lockout disables all panel keys
// - group trigger samples once when external and not busy
// - execution error on bad trigger or compensation
// - query error when response exceeds limit
// - command error on unexpected parameters
// - self-test answer ranges 0 to 15
// - enabled status bit rise sets master summary
// - masked standard events set status bit 5
`ifndef EVENT_STATUS_DEFINES_VH
`define EVENT_STATUS_DEFINES_VH

// command codes on cmd_code_i
`define CMD_NONE        4'h0
`define CMD_CLS         4'h1
`define CMD_READ_STB    4'h2
`define CMD_READ_SRE    4'h3
`define CMD_WRITE_SRE   4'h4
`define CMD_READ_ESR    4'h5
`define CMD_READ_ESE    4'h6
`define CMD_WRITE_ESE   4'h7
`define CMD_READ_MEAS   4'h8
`define CMD_READ_MMASK  4'h9
`define CMD_WRITE_MMASK 4'hA
`define CMD_READ_COMP   4'hB
`define CMD_READ_CMASK  4'hC
`define CMD_WRITE_CMASK 4'hD
`define CMD_TRIGGER     4'hE
`define CMD_SELFTEST    4'hF

// status byte positions
`define STB_MEAS_SUM    0
`define STB_COMP_SUM    1
`define STB_MSG_AVAIL   4
`define STB_STD_SUM     5
`define STB_MASTER      6

// standard event positions
`define SEV_QUERY_ERR   2
`define SEV_EXEC_ERR    4
`define SEV_CMD_ERR     5

// measurement flags layout
`define MEAS_COMP_DONE  0
`define MEAS_DONE       1
`define MEAS_IMP_UNDER  3
`define MEAS_IMP_OVER   4
`define MEAS_LIMIT_OVF  5
`define MEAS_CC_OVF     6
`define MEAS_USED_MASK  8'h7B

// comparator flags layout
`define CMP_FIRST_HIGH  0
`define CMP_FIRST_PASS  1
`define CMP_FIRST_LOW   2
`define CMP_THIRD_HIGH  3
`define CMP_THIRD_PASS  4
`define CMP_THIRD_LOW   5
`define CMP_BOTH_PASS   6
`define CMP_USED_MASK   8'h3F

`define RESET_BYTE      8'h00
`define SELFTEST_MAX    8'h0F
`define RESP_LIMIT      14'h2800

`endif

// ---- hdl/event_flag_reg.v ----
// one sticky eight-bit event register with query-clear
// assumes events are single-cycle or level flags on the instrument clock
`timescale 1ns/1ps
module event_flag_reg #(
   parameter WIDTH = 8
) (
   // clock and reset
   input  wire             clk_sys_i,
   input  wire             rstn_i,
   // control
   input  wire [WIDTH-1:0] set_i,
   input  wire             clear_i,
   // state
   output reg  [WIDTH-1:0] flags_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // a set in the same cycle as a clear survives so no event is lost
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags_o <= {WIDTH{1'b0}};
      end else if (clear_i) begin
         flags_o <= set_i;
      end else begin
         flags_o <= flags_o | set_i;
      end
   end

endmodule

// ---- dv/event_status_summary_chk.sv ----
// assertions on the ports of the status reporting block
// assumes the defines header is on the include path
`timescale 1ns/1ps
`include "event_status_defines.vh"
module event_status_summary_chk #(
   parameter RESP_WIDTH = 14
) (
   // clock and reset
   input wire logic                  clk_sys_i,
   input wire logic                  rstn_i,
   // watched inputs
   input wire logic                  cmd_valid_i,
   input wire logic [3:0]            cmd_code_i,
   input wire logic [RESP_WIDTH-1:0] resp_len_i,
   input wire logic [3:0]            selftest_result_i,
   input wire logic                  msg_dev_clear_i,
   input wire logic                  msg_go_local_i,
   input wire logic                  msg_lockout_i,
   input wire logic                  msg_remote_i,
   input wire logic                  msg_trigger_i,
   input wire logic                  serial_poll_i,
   input wire logic                  trig_external_i,
   input wire logic                  comp_busy_i,
   // watched outputs
   input wire logic                  resp_valid_o,
   input wire logic                  status_byte_o,
   input wire logic [7:0]            resp_data_o,
   input wire logic                  srq_o,
   input wire logic                  remote_o,
   input wire logic                  panel_locked_o,
   input wire logic                  flush_buffers_o,
   input wire logic                  sample_once_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////////////////////////
   // one bit per command code that returns a byte
   localparam logic [15:0] query_map = 16'h9B6C;
   wire q    = cmd_valid_i && query_map[cmd_code_i];
   wire long = resp_len_i > `RESP_LIMIT;
   // a device clear in the same cycle empties the output queue
   wire ok   = q && !long && !msg_dev_clear_i;
   wire trg  = cmd_valid_i && (cmd_code_i == `CMD_TRIGGER);
   sequence go_ext;
      msg_trigger_i && trig_external_i && !comp_busy_i;
   endsequence
   sequence quiet;
      !msg_trigger_i && !trg;
   endsequence
   sequence one_shot;
      sample_once_o ##1 !sample_once_o;
   endsequence
   AST_ANSWER: assert property (ok |=> resp_valid_o)
      else $error("query got no answer");
   AST_TOO_LONG: assert property (q && long && !serial_poll_i |=> !resp_valid_o)
      else $error("over-long answer was sent");
   AST_DATA_HOLD: assert property (!q && !serial_poll_i |=> $stable(resp_data_o))
      else $error("answer byte changed without a query");
   AST_SELFTEST: assert property (ok && !serial_poll_i && cmd_code_i == `CMD_SELFTEST
      |=> resp_data_o == {4'h0, $past(selftest_result_i)}) else $error("self-test byte wrong");
   AST_FLUSH: assert property (msg_dev_clear_i |=> flush_buffers_o)
      else $error("clear did not flush");
   AST_LOCAL: assert property (msg_go_local_i && !msg_remote_i |=> !remote_o)
      else $error("still remote after go-to-local");
   AST_LOCK: assert property (msg_lockout_i && !msg_go_local_i |=> panel_locked_o)
      else $error("panel not locked");
   AST_ONE_SHOT: assert property (go_ext ##1 quiet |-> one_shot)
      else $error("trigger did not sample exactly once");
   AST_NO_SAMPLE: assert property ((msg_trigger_i || trg) && !trig_external_i
      |=> !sample_once_o) else $error("sampled in internal mode");
   AST_SRQ_STANDS: assert property (srq_o && !serial_poll_i |=> srq_o)
      else $error("request dropped without a poll");
   AST_POLL: assert property (serial_poll_i
      |=> status_byte_o && resp_data_o[`STB_MASTER] == $past(srq_o))
      else $error("poll byte wrong");
endmodule

// ---- dv/bus_ctrl_model.sv ----
// behavioural bus controller issuing decoded commands and interface messages
// assumes the device answers a query in the cycle after it is taken
`timescale 1ns/1ps
module bus_ctrl_model (
   // clock and answers
   input  wire logic        clk_sys_i,
   input  wire logic        resp_valid_i,
   input  wire logic [7:0]  resp_data_i,
   // commands: flags are has_param, takes_param, from_parallel
   output logic             cmd_valid_o,
   output logic [3:0]       cmd_code_o,
   output logic [7:0]       cmd_data_o,
   output logic [2:0]       cmd_flags_o,
   output logic [13:0]      resp_len_o,
   // messages: poll, trigger, remote, lockout, local, clear
   output logic [5:0]       msg_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = 4'h0;
      cmd_data_o  = 8'h00;
      cmd_flags_o = 3'h1;
      resp_len_o  = 14'h0000;
      msg_o       = 6'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // mask values only ever travel as whole bytes, so 0 to 255 by construction
   task automatic cmd(input [3:0] c, input [7:0] d, input [2:0] f, input [13:0] len,
                      output logic [7:0] rd, output logic rv);
      @(posedge clk_sys_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_code_o  = c;
      cmd_data_o  = d;
      cmd_flags_o = f;
      resp_len_o  = len;
      @(posedge clk_sys_i);
      #1;
      rv = resp_valid_i;
      rd = resp_data_i;
      // released data shows garbage, not the last byte
      cmd_valid_o = 1'b0;
      cmd_data_o  = ~cmd_data_o;
   endtask
   task automatic msg(input [5:0] m);
      @(posedge clk_sys_i);
      #1;
      msg_o = m;
      @(posedge clk_sys_i);
      #1;
      msg_o = 6'h00;
   endtask
endmodule

// ---- dv/event_status_summary_tb_top.sv ----
// self-checking bench for the status reporting block
// assumes the controller model and checker files are compiled first
`timescale 1ns/1ps
`include "event_status_defines.vh"
module event_status_summary_tb_top;
   logic clk_sys_i, rstn_i, trig_ext, busy, cmp_v, pon, pend, rv;
   logic [3:0] reset_codes [7] = '{4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hB, 4'hC};
   logic [3:0] st_res;
   logic [7:0] meas_ev, rd;
   logic [5:0] cmp;
   wire cmd_valid, resp_valid, stb_flag, srq, remote, locked, flush, sample;
   wire [3:0] cmd_code;
   wire [7:0] cmd_data, resp_data;
   wire [2:0] fl;
   wire [13:0] len;
   wire [5:0] m;
   int num_errors = 0;
   int checks = 0;
   bus_ctrl_model u_bus_ctrl_model (.clk_sys_i(clk_sys_i), .resp_valid_i(resp_valid),
      .resp_data_i(resp_data), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_data_o(cmd_data), .cmd_flags_o(fl), .resp_len_o(len), .msg_o(m));
   event_status_summary u_event_status_summary (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
      .cmd_has_param_i(fl[2]), .cmd_takes_param_i(fl[1]), .cmd_from_parallel_i(fl[0]),
      .resp_len_i(len), .msg_dev_clear_i(m[0]), .msg_go_local_i(m[1]),
      .msg_lockout_i(m[2]), .msg_remote_i(m[3]), .msg_trigger_i(m[4]), .serial_poll_i(m[5]),
      .trig_external_i(trig_ext), .comp_busy_i(busy), .output_pending_i(pend),
      .selftest_result_i(st_res), .meas_event_i(meas_ev), .compare_i(cmp),
      .compare_valid_i(cmp_v), .power_on_event_i(pon), .resp_valid_o(resp_valid),
      .resp_data_o(resp_data), .status_byte_o(stb_flag), .srq_o(srq), .remote_o(remote),
      .panel_locked_o(locked), .flush_buffers_o(flush), .sample_once_o(sample));
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic q(input [3:0] c, input [7:0] e, input string n, input [13:0] l = 14'h0);
      u_bus_ctrl_model.cmd(c, 8'h00, 3'b001, l, rd, rv);
      check({n, " valid"}, {7'h0, rv}, 8'h01);
      check(n, rd, e);
   endtask
   task automatic wr(input [3:0] c, input [7:0] d, input [2:0] f = 3'b111);
      u_bus_ctrl_model.cmd(c, d, f, 14'h0, rd, rv);
   endtask
   // a one-cycle burst of instrument events; compare lines idle with garbage
   task automatic ev(input [7:0] me, input [5:0] c);
      @(posedge clk_sys_i);
      #1;
      {meas_ev, cmp, cmp_v, pon} = {me, c, 1'b1, me == 8'h00 && c == 6'h3F};
      @(posedge clk_sys_i);
      #1;
      {meas_ev, cmp, cmp_v, pon} = {8'h00, ~cmp, 2'b00};
   endtask
   initial begin
      {rstn_i, trig_ext, busy, cmp_v, pon, pend, st_res, meas_ev, cmp} = '0;
      repeat (10) @(posedge clk_sys_i);
      #1 rstn_i = 1'b1;
      for (int i = 0; i < 7; i++) begin
         q(reset_codes[i], 8'h00, "reset value");
      end
      wr(`CMD_WRITE_SRE, 8'h23);
      q(`CMD_READ_SRE, 8'h23, "sre");
      wr(`CMD_WRITE_ESE, 8'h30);
      wr(`CMD_WRITE_ESE, 8'hFF, 3'b110);
      q(`CMD_READ_ESE, 8'h30, "ese");
      q(`CMD_READ_ESR, 8'h10, "esr serial write");
      q(`CMD_READ_ESR, 8'h00, "esr cleared");
      wr(`CMD_WRITE_MMASK, 8'h01);
      ev(8'h02, 6'h00);
      q(`CMD_READ_STB, 8'h00, "stb masked");
      wr(`CMD_WRITE_MMASK, 8'h02);
      q(`CMD_READ_MMASK, 8'h02, "mmask");
      q(`CMD_READ_STB, 8'h41, "stb meas");
      check("srq", {7'h0, srq}, 8'h01);
      q(`CMD_READ_MEAS, 8'h02, "meas");
      q(`CMD_READ_MEAS, 8'h00, "meas cleared");
      u_bus_ctrl_model.msg(6'h20);
      check("poll flag", {7'h0, stb_flag}, 8'h01);
      check("poll byte", resp_data, 8'h40);
      check("srq poll", {7'h0, srq}, 8'h00);
      ev(8'h00, 6'b010_010);
      wr(`CMD_WRITE_CMASK, 8'h40);
      q(`CMD_READ_CMASK, 8'h40, "cmask");
      q(`CMD_READ_STB, 8'h42, "stb comp");
      q(`CMD_READ_COMP, 8'h52, "comp pass");
      ev(8'h00, 6'b100_100);
      q(`CMD_READ_COMP, 8'h24, "comp low");
      ev(8'hFF, 6'h15);
      wr(`CMD_CLS, 8'h00, 3'b001);
      q(`CMD_READ_MEAS, 8'h00, "cls meas");
      q(`CMD_READ_COMP, 8'h00, "cls comp");
      ev(8'hFF, 6'h00);
      q(`CMD_READ_MEAS, 8'h7B, "meas layout");
      wr(`CMD_CLS, 8'h00, 3'b101);
      q(`CMD_READ_ESR, 8'h20, "esr param");
      u_bus_ctrl_model.cmd(`CMD_READ_SRE, 8'h00, 3'b001, 14'h2801, rd, rv);
      check("long valid", {7'h0, rv}, 8'h00);
      q(`CMD_READ_ESR, 8'h04, "esr query", 14'h2800);
      wr(`CMD_TRIGGER, 8'h00, 3'b001);
      check("internal sample", {7'h0, sample}, 8'h00);
      q(`CMD_READ_ESR, 8'h10, "esr trigger");
      busy = 1'b1;
      wr(`CMD_WRITE_MMASK, 8'hFF);
      busy = 1'b0;
      q(`CMD_READ_MMASK, 8'h02, "busy mask");
      q(`CMD_READ_ESR, 8'h10, "esr busy");
      u_bus_ctrl_model.msg(6'h08);
      check("remote on", {7'h0, remote}, 8'h01);
      u_bus_ctrl_model.msg(6'h02);
      check("remote", {7'h0, remote}, 8'h00);
      u_bus_ctrl_model.msg(6'h04);
      check("locked", {7'h0, locked}, 8'h01);
      u_bus_ctrl_model.msg(6'h01);
      check("flush", {7'h0, flush}, 8'h01);
      trig_ext = 1'b1;
      u_bus_ctrl_model.msg(6'h10);
      check("sample", {7'h0, sample}, 8'h01);
      st_res = 4'hF;
      q(`CMD_SELFTEST, 8'h0F, "selftest");
      ev(8'h00, 6'h3F);
      q(`CMD_READ_STB, 8'h42, "stb std masked");
      wr(`CMD_WRITE_ESE, 8'h80);
      q(`CMD_READ_STB, 8'h62, "stb std");
      pend = 1'b1;
      q(`CMD_READ_STB, 8'h72, "stb pending");
      summarize();
   end
   initial begin
      #100000;
      num_errors++;
      summarize();
   end
endmodule
bind event_status_summary event_status_summary_chk #(.RESP_WIDTH(RESP_WIDTH)) u_chk (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
   .cmd_code_i(cmd_code_i), .resp_len_i(resp_len_i), .selftest_result_i(selftest_result_i),
   .msg_dev_clear_i(msg_dev_clear_i), .msg_go_local_i(msg_go_local_i),
   .msg_lockout_i(msg_lockout_i), .msg_remote_i(msg_remote_i), .msg_trigger_i(msg_trigger_i),
   .serial_poll_i(serial_poll_i), .trig_external_i(trig_external_i), .comp_busy_i(comp_busy_i),
   .resp_valid_o(resp_valid_o), .status_byte_o(status_byte_o),
   .resp_data_o(resp_data_o), .srq_o(srq_o),
   .remote_o(remote_o), .panel_locked_o(panel_locked_o),
   .flush_buffers_o(flush_buffers_o), .sample_once_o(sample_once_o));
